//--- core/pcof_pkg.sv
// constants, types and carriers of the pipeline command order and fence block
// assumes one core clock shared by the apb side and the command stream
// Functional notes
// R01 - routine pointer bits 31:4 are 16-byte offset from general or instruction base
// R02 - one routine address shared by all threads, always 16-byte aligned
// R03 - issuer flushes the active pipeline right before switching pipelines
// R04 - pipe sync command works on either pipe without fence or other state
// R05 - issuer programs entry count and size before the fence relying on them
// R06 - streamer from streamer config, 3d units from 3d pointers, media from media
// R07 - issuer sets common state before the first draw or media object
// R08 - issuer sets all 3d state before a draw command
// R09 - issuer sets media pointers before any media object
// R10 - fence goes to streamer first, then down the selected pipeline units
// R11 - unit reallocates only when enabled and its fence update enable is set
// R12 - release of held entries overlaps allocation of new handles
// R13 - streamer reallocation invalidates constants; issuer must reload them
// R14 - new allocation from fence value with the unit's count and size
// R15 - only a fence starts reallocation, entry state writes never do
// R16 - issuer fences a unit after changing its count, size or thread limit
// R17 - fence may change alone but must stay consistent with count and size
// R18 - draw, media object or constant upload with an unfenced change flags error
package pcof_pkg;
	localparam int NU = 5;
	localparam int CW = 8;
	localparam int FW = 16;
	localparam logic [NU-1:0] MASK_3D = 5'h0e;
	localparam logic [NU-1:0] MASK_MEDIA = 5'h10;
	localparam logic [NU-1:0] MASK_THR = 5'h0c;
	// field positions inside a command data word, and for F_ENA inside the control register
	localparam int F_CNT = 0;
	localparam int F_SIZE = 8;
	localparam int F_THR = 16;
	localparam int F_UPD = 16;
	localparam int F_ENA = 8;
	// register byte offsets
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STAT = 12'h004;
	localparam logic [11:0] A_ISTAT = 12'h008;
	localparam logic [11:0] A_IMASK = 12'h00c;
	localparam logic [11:0] A_RADDR = 12'h010;
	localparam logic [31:0] CTRL_RST = 32'h00001f00;
	// event bits
	localparam int EV_FENCE = 0;
	localparam int EV_ORDER = 1;
	localparam int EV_SWITCH = 2;
	localparam int EV_ALLOC = 3;
	localparam int NEV = 4;
	typedef enum logic [3:0] {
		OP_NOP, OP_SELECT, OP_FLUSH, OP_SYNC, OP_SCFG, OP_3DPTR, OP_MPTR,
		OP_RPTR, OP_BASE, OP_FVAL, OP_FENCE, OP_DRAW, OP_MOBJ, OP_CONST
	} pcof_op_t;
	typedef struct packed {
		logic valid;
		pcof_op_t op;
		logic [2:0] unit;
		logic [31:0] data;
	} pcof_cmd_t;
	typedef struct packed {
		logic go;
		logic release_old;
		logic [2:0] unit;
		logic [FW-1:0] base;
		logic [FW-1:0] limit;
		logic [CW-1:0] count;
		logic [CW-1:0] size;
	} pcof_ff_t;
endpackage

//--- core/pcof_core.sv
// command order checker and entry fence sequencer with apb registers
// assumes commands arrive on pclk from the stream parser, one per accepted cycle
module pcof_core #(
	parameter int UNITS = pcof_pkg::NU
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pcof_pkg::pcof_cmd_t cmd,
	output logic cmd_ready,
	output pcof_pkg::pcof_ff_t ff_out,
	output logic sync_pulse,
	output logic [31:0] routine_addr,
	output logic irq
);
	localparam int NU = pcof_pkg::NU;
	localparam int CW = pcof_pkg::CW;
	localparam int FW = pcof_pkg::FW;

	if (UNITS != NU) begin : g_chk
		$error("pcof_core: UNITS must equal the package unit count");
	end

	typedef struct packed {
		logic [31:0] ctrl;
		logic [pcof_pkg::NEV-1:0] istat;
		logic [pcof_pkg::NEV-1:0] imask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pipe;
		logic flushed;
		logic const_ok;
		logic walking;
		logic [2:0] idx;
		logic [FW-1:0] pbase;
		logic [NU-1:0][CW-1:0] cnt;
		logic [NU-1:0][CW-1:0] size;
		logic [NU-1:0][CW-1:0] thr;
		logic [NU-1:0][FW-1:0] fval;
		logic [NU-1:0] fupd;
		logic [NU-1:0] dirty;
		logic [31:0] gbase;
		logic [31:0] ibase;
		logic [31:0] raddr;
		logic cmd_ready;
		logic sync;
		pcof_pkg::pcof_ff_t ff;
		logic irq;
	} pcof_state_t;

	pcof_state_t s_ff;
	pcof_state_t nxt_s;
	logic acc;
	logic [NU-1:0] ena;
	logic [NU-1:0] pmask;
	logic [pcof_pkg::NEV-1:0] ev;
	logic [FW-1:0] need;
	logic member;
	logic [CW-1:0] dc;
	logic [CW-1:0] ds;
	logic [CW-1:0] dt;
	logic wr;
	logic rd;

	assign acc = cmd.valid & s_ff.cmd_ready;
	assign dc = cmd.data[pcof_pkg::F_CNT +: CW];
	assign ds = cmd.data[pcof_pkg::F_SIZE +: CW];
	assign dt = cmd.data[pcof_pkg::F_THR +: CW];
	// streamer cannot be disabled, others follow the enable field
	assign ena = s_ff.ctrl[pcof_pkg::F_ENA +: NU] | {{(NU-1){1'b0}}, 1'b1};
	assign pmask = s_ff.pipe ? pcof_pkg::MASK_MEDIA : pcof_pkg::MASK_3D;
	// write lands on the edge at which the master sees pready high
	assign wr = psel & penable & pwrite & s_ff.pready;
	assign rd = psel & penable & ~s_ff.pready;

	always_comb begin
		nxt_s = s_ff;
		ev = '0;
		member = 1'b0;
		need = '0;
		nxt_s.sync = 1'b0;
		nxt_s.ff.go = 1'b0;
		nxt_s.ff.release_old = 1'b0;
		// apb slave, one wait state so prdata comes from a flop
		nxt_s.pready = psel & penable & ~s_ff.pready;
		if (rd) begin
			nxt_s.pslverr = 1'b0;
			case (paddr)
				pcof_pkg::A_CTRL: nxt_s.prdata = s_ff.ctrl;
				pcof_pkg::A_STAT: nxt_s.prdata = {19'h0, s_ff.dirty, 4'h0,
					s_ff.flushed, s_ff.const_ok, s_ff.walking, s_ff.pipe};
				pcof_pkg::A_ISTAT: nxt_s.prdata = {28'h0, s_ff.istat};
				pcof_pkg::A_IMASK: nxt_s.prdata = {28'h0, s_ff.imask};
				pcof_pkg::A_RADDR: nxt_s.prdata = s_ff.raddr;
				default: begin
					nxt_s.prdata = 32'h0;
					nxt_s.pslverr = 1'b1;
				end
			endcase
		end
		if (wr) begin
			case (paddr)
				pcof_pkg::A_CTRL: nxt_s.ctrl = pwdata & 32'h00001f01;
				pcof_pkg::A_IMASK: nxt_s.imask = pwdata[pcof_pkg::NEV-1:0];
				default: nxt_s.ctrl = nxt_s.ctrl;
			endcase
		end
		// fence walk, one unit per cycle in pipeline order
		if (s_ff.walking) begin
			member = (s_ff.idx == 3'h0) | pmask[s_ff.idx]; // R10
			if (member & ena[s_ff.idx]) begin
				nxt_s.pbase = s_ff.fval[s_ff.idx];
				if (s_ff.fupd[s_ff.idx]) begin // R11
					need = s_ff.cnt[s_ff.idx] * s_ff.size[s_ff.idx]; // R14
					nxt_s.ff.go = 1'b1;
					nxt_s.ff.release_old = 1'b1; // R12
					nxt_s.ff.unit = s_ff.idx;
					nxt_s.ff.base = s_ff.pbase;
					nxt_s.ff.limit = s_ff.fval[s_ff.idx];
					nxt_s.ff.count = s_ff.cnt[s_ff.idx];
					nxt_s.ff.size = s_ff.size[s_ff.idx];
					nxt_s.dirty[s_ff.idx] = 1'b0;
					// a fence below the previous one or too small is flagged, not dropped
					if (s_ff.fval[s_ff.idx] < s_ff.pbase
						|| need > s_ff.fval[s_ff.idx] - s_ff.pbase) begin
						ev[pcof_pkg::EV_ALLOC] = 1'b1;
					end
					if (s_ff.idx == 3'h0) begin
						nxt_s.const_ok = 1'b0; // R13
					end
				end
			end
			if (s_ff.idx == 3'(NU - 1)) begin
				nxt_s.walking = 1'b0;
				nxt_s.fupd = '0;
				ev[pcof_pkg::EV_FENCE] = 1'b1;
			end else begin
				nxt_s.idx = s_ff.idx + 3'h1;
			end
		end
		// command decode
		if (acc) begin
			nxt_s.flushed = (cmd.op == pcof_pkg::OP_FLUSH);
			case (cmd.op)
				pcof_pkg::OP_SELECT: begin
					// a switch without a preceding flush is reported but still done
					if (cmd.data[0] != s_ff.pipe && !s_ff.flushed) begin
						ev[pcof_pkg::EV_SWITCH] = 1'b1; // R03
					end
					nxt_s.pipe = cmd.data[0];
				end
				pcof_pkg::OP_SYNC: nxt_s.sync = 1'b1; // R04
				pcof_pkg::OP_SCFG: begin
					// entry state writes only mark the unit, never reallocate
					nxt_s.dirty[0] = s_ff.dirty[0] | (dc != s_ff.cnt[0])
						| (ds != s_ff.size[0]); // R15
					nxt_s.cnt[0] = dc; // R06
					nxt_s.size[0] = ds;
				end
				pcof_pkg::OP_3DPTR, pcof_pkg::OP_MPTR: begin
					if (cmd.unit < 3'(NU) && ((cmd.op == pcof_pkg::OP_3DPTR) ?
						pcof_pkg::MASK_3D[cmd.unit] : pcof_pkg::MASK_MEDIA[cmd.unit])) begin
						nxt_s.dirty[cmd.unit] = s_ff.dirty[cmd.unit] | (ena[cmd.unit]
							& ((dc != s_ff.cnt[cmd.unit]) | (ds != s_ff.size[cmd.unit])
							| (pcof_pkg::MASK_THR[cmd.unit] & (dt != s_ff.thr[cmd.unit]))));
						nxt_s.cnt[cmd.unit] = dc; // R06
						nxt_s.size[cmd.unit] = ds;
						nxt_s.thr[cmd.unit] = dt;
					end
				end
				pcof_pkg::OP_BASE: begin
					if (cmd.unit[0]) begin
						nxt_s.ibase = {cmd.data[31:4], 4'h0};
					end else begin
						nxt_s.gbase = {cmd.data[31:4], 4'h0};
					end
				end
				pcof_pkg::OP_RPTR: begin
					// one shared address, low nibble forced clear for alignment
					nxt_s.raddr = (s_ff.ctrl[0] ? s_ff.ibase : s_ff.gbase)
						+ {cmd.data[31:4], 4'h0}; // R01 R02
				end
				pcof_pkg::OP_FVAL: begin
					if (cmd.unit < 3'(NU)) begin
						nxt_s.fval[cmd.unit] = cmd.data[FW-1:0];
						nxt_s.fupd[cmd.unit] = cmd.data[pcof_pkg::F_UPD];
					end
				end
				pcof_pkg::OP_FENCE: begin
					nxt_s.walking = 1'b1; // R15
					nxt_s.idx = 3'h0;
					nxt_s.pbase = '0;
				end
				pcof_pkg::OP_DRAW, pcof_pkg::OP_MOBJ, pcof_pkg::OP_CONST: begin
					if (|(s_ff.dirty & ena & (pmask | {{(NU-1){1'b0}}, 1'b1}))) begin
						ev[pcof_pkg::EV_ORDER] = 1'b1; // R18
					end
					if (cmd.op == pcof_pkg::OP_CONST) begin
						nxt_s.const_ok = 1'b1; // R13
					end
				end
				default: nxt_s.sync = 1'b0;
			endcase
		end
		// stall the stream while a fence walks down the units
		nxt_s.cmd_ready = ~nxt_s.walking;
		// new events win over a write-one-to-clear in the same cycle
		nxt_s.istat = (s_ff.istat & ~(wr && paddr == pcof_pkg::A_ISTAT ?
			pwdata[pcof_pkg::NEV-1:0] : 4'h0)) | ev;
		nxt_s.irq = |(nxt_s.istat & nxt_s.imask);
	end

	// all state frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
			s_ff.ctrl <= pcof_pkg::CTRL_RST;
			s_ff.cmd_ready <= 1'b1;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign cmd_ready = s_ff.cmd_ready;
	assign ff_out = s_ff.ff;
	assign sync_pulse = s_ff.sync;
	assign routine_addr = s_ff.raddr;
	assign irq = s_ff.irq;

	// checks on the fence walk and command handling
	sequence s_fence_acc;
		acc && cmd.op == pcof_pkg::OP_FENCE;
	endsequence
	sequence s_walk_end;
		s_ff.walking ##1 !s_ff.walking && s_ff.istat[pcof_pkg::EV_FENCE];
	endsequence
	property p_fence_done;
		@(posedge pclk) disable iff (!presetn || !ce)
		s_fence_acc |=> s_ff.walking [*5] ##0 s_walk_end;
	endproperty
	a_fence_done: assert property (p_fence_done) else $error("fence walk length wrong"); // R10
	property p_order;
		@(posedge pclk) disable iff (!presetn || !ce)
		ff_out.go |-> (ff_out.unit == 3'h0 || pmask[ff_out.unit]);
	endproperty
	a_order: assert property (p_order) else $error("unit outside selected pipeline"); // R10
	property p_gate;
		@(posedge pclk) disable iff (!presetn || !ce)
		ff_out.go |-> ena[ff_out.unit] && ff_out.release_old;
	endproperty
	a_gate: assert property (p_gate) else $error("disabled unit reallocated"); // R11 R12
	property p_cfg_quiet;
		@(posedge pclk) disable iff (!presetn || !ce)
		acc && !s_ff.walking && cmd.op inside {pcof_pkg::OP_SCFG, pcof_pkg::OP_3DPTR,
			pcof_pkg::OP_MPTR} |=> !ff_out.go [*2];
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("state write reallocated"); // R15
	property p_sync;
		@(posedge pclk) disable iff (!presetn || !ce)
		acc && cmd.op == pcof_pkg::OP_SYNC |=> sync_pulse ##1 !sync_pulse;
	endproperty
	a_sync: assert property (p_sync) else $error("sync not executed"); // R04
	property p_rptr;
		@(posedge pclk) disable iff (!presetn || !ce)
		acc && cmd.op == pcof_pkg::OP_RPTR |=> routine_addr[3:0] == 4'h0
			&& routine_addr == ($past(s_ff.ctrl[0]) ? $past(s_ff.ibase) : $past(s_ff.gbase))
			+ {$past(cmd.data[31:4]), 4'h0};
	endproperty
	a_rptr: assert property (p_rptr) else $error("routine address wrong"); // R01 R02
	property p_const;
		@(posedge pclk) disable iff (!presetn || !ce)
		ff_out.go && ff_out.unit == 3'h0 |-> !s_ff.const_ok;
	endproperty
	a_const: assert property (p_const) else $error("constants kept after realloc"); // R13
	property p_err;
		@(posedge pclk) disable iff (!presetn || !ce)
		acc && cmd.op == pcof_pkg::OP_DRAW && |(s_ff.dirty & ena & pmask)
			|=> s_ff.istat[pcof_pkg::EV_ORDER];
	endproperty
	a_err: assert property (p_err) else $error("ordering error not flagged"); // R18
	property p_alloc;
		@(posedge pclk) disable iff (!presetn || !ce)
		ff_out.go && ff_out.limit >= ff_out.base
			&& 16'(ff_out.count) * 16'(ff_out.size) > ff_out.limit - ff_out.base
			|-> s_ff.istat[pcof_pkg::EV_ALLOC];
	endproperty
	a_alloc: assert property (p_alloc) else $error("overflow not flagged"); // R14
endmodule

//--- testbench/pcof_stream_model.sv
// command stream source standing in for the driver-written ring buffer
// assumes send is called right after a rising edge of pclk
module pcof_stream_model (
	input wire logic pclk,
	input wire logic cmd_ready,
	output pcof_pkg::pcof_cmd_t cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	// commands never taken within the bound; the bench counts them as mismatches
	int stuck = 0;
	initial cmd = '0;
	// hold the command until taken; the idle payload is inverted so stale data never matches
	task automatic send(input pcof_pkg::pcof_op_t op, input logic [2:0] u, input logic [31:0] d);
		int n;
		n = 0;
		cmd <= '{1'b1, op, u, d};
		@(posedge pclk);
		while (cmd_ready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (cmd_ready !== 1'b1)
			stuck++;
		cmd <= '{1'b0, pcof_pkg::OP_NOP, ~u, ~d};
		@(posedge pclk);
	endtask
endmodule

//--- testbench/pipeline_cmd_order_fence_tb.sv
// self-checking bench: apb register tasks plus command sequences through the stream model
// assumes the design answers apb with one wait state and fences walk five units
module pipeline_cmd_order_fence_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, routine_addr, rd;
	logic pready, pslverr, cmd_ready, sync_pulse, irq, err;
	pcof_pkg::pcof_cmd_t cmd;
	pcof_pkg::pcof_ff_t ff_out;
	pcof_pkg::pcof_ff_t gq[$];
	int fails = 0, total_checks = 0, rdy_low = 0, sync_n = 0;
	pcof_core pcof_core_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd(cmd), .cmd_ready(cmd_ready), .ff_out(ff_out),
		.sync_pulse(sync_pulse), .routine_addr(routine_addr), .irq(irq));
	pcof_stream_model pcof_stream_model_i (.pclk(pclk), .cmd_ready(cmd_ready), .cmd(cmd));
	initial begin
		forever #5 pclk = ~pclk;
	end
	// record every unit reallocation, stalled cycle and sync pulse as it is sampled
	always @(posedge pclk) begin
		if (ff_out.go === 1'b1)
			gq.push_back(ff_out);
		if (cmd_ready === 1'b0)
			rdy_low++;
		if (sync_pulse === 1'b1)
			sync_n++;
	end
	task automatic summarize();
		fails += pcof_stream_model_i.stuck;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (pready !== 1'b1) begin
			fails++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(rd, exp);
	endtask
	task automatic gchk(input int i, input logic [2:0] u, input logic [15:0] l,
		input logic [7:0] c, input logic [7:0] s);
		chk({gq[i].unit, gq[i].release_old, gq[i].limit, gq[i].count, gq[i].size},
			{u, 1'b1, l, c, s});
	endtask
	task automatic fence();
		gq.delete();
		rdy_low = 0;
		pcof_stream_model_i.send(pcof_pkg::OP_FENCE, 3'h0, 32'h0);
		repeat (8) @(posedge pclk);
	endtask
	initial begin
		#300000;
		fails++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(pcof_pkg::A_CTRL, pcof_pkg::CTRL_RST);
		rchk(pcof_pkg::A_ISTAT, 32'h0);
		rchk(12'h020, 32'h0);
		chk(err, 1'b1);
		$display("test reset done");
		// routine pointer against both bases
		pcof_stream_model_i.send(pcof_pkg::OP_BASE, 3'h0, 32'h0001_0000);
		pcof_stream_model_i.send(pcof_pkg::OP_BASE, 3'h1, 32'h0020_0000);
		pcof_stream_model_i.send(pcof_pkg::OP_RPTR, 3'h0, 32'h0000_1235);
		chk(routine_addr, 32'h0001_1230);
		apb(1'b1, pcof_pkg::A_CTRL, 32'h0000_1f01);
		pcof_stream_model_i.send(pcof_pkg::OP_RPTR, 3'h0, 32'h0000_1235);
		rchk(pcof_pkg::A_RADDR, 32'h0020_1230);
		$display("test routine done");
		// sync on both pipes, flushed switch, then an unflushed switch
		pcof_stream_model_i.send(pcof_pkg::OP_SYNC, 3'h0, 32'h0);
		pcof_stream_model_i.send(pcof_pkg::OP_FLUSH, 3'h0, 32'h0);
		pcof_stream_model_i.send(pcof_pkg::OP_SELECT, 3'h0, 32'h1);
		pcof_stream_model_i.send(pcof_pkg::OP_SYNC, 3'h0, 32'h0);
		rchk(pcof_pkg::A_ISTAT, 32'h0);
		chk(sync_n, 2);
		pcof_stream_model_i.send(pcof_pkg::OP_SELECT, 3'h0, 32'h0);
		rchk(pcof_pkg::A_ISTAT, 32'h4);
		apb(1'b1, pcof_pkg::A_ISTAT, 32'h4);
		rchk(pcof_pkg::A_ISTAT, 32'h0);
		$display("test sync done");
		// entry state first, then fence values, then the fence walk
		pcof_stream_model_i.send(pcof_pkg::OP_SCFG, 3'h0, 32'h0000_0802);
		pcof_stream_model_i.send(pcof_pkg::OP_3DPTR, 3'h1, 32'h0000_0c04);
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h0, 32'h0001_0010);
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h1, 32'h0001_0040);
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h2, 32'h0000_0080);
		chk(gq.size(), 0);
		fence();
		chk(rdy_low, 5);
		chk(gq.size(), 2);
		gchk(0, 3'h0, 16'h0010, 8'h02, 8'h08);
		gchk(1, 3'h1, 16'h0040, 8'h04, 8'h0c);
		chk({gq[0].base, gq[1].base}, {16'h0, 16'h0010});
		rchk(pcof_pkg::A_ISTAT, 32'h1);
		$display("test fence done");
		// constants lost on a streamer reallocation
		pcof_stream_model_i.send(pcof_pkg::OP_CONST, 3'h0, 32'h0);
		apb(1'b0, pcof_pkg::A_STAT, '0);
		chk(rd[2], 1'b1);
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h0, 32'h0001_0010);
		fence();
		apb(1'b0, pcof_pkg::A_STAT, '0);
		chk(rd[2], 1'b0);
		$display("test constants done");
		// unfenced count change before a draw raises the masked interrupt
		apb(1'b1, pcof_pkg::A_ISTAT, 32'hf);
		apb(1'b1, pcof_pkg::A_IMASK, 32'h2);
		pcof_stream_model_i.send(pcof_pkg::OP_SCFG, 3'h0, 32'h0000_0803);
		pcof_stream_model_i.send(pcof_pkg::OP_DRAW, 3'h0, 32'h0);
		rchk(pcof_pkg::A_ISTAT, 32'h2);
		chk(irq, 1'b1);
		apb(1'b1, pcof_pkg::A_IMASK, 32'h0);
		chk(irq, 1'b0);
		apb(1'b1, pcof_pkg::A_ISTAT, 32'h2);
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h0, 32'h0001_0018);
		fence();
		pcof_stream_model_i.send(pcof_pkg::OP_DRAW, 3'h0, 32'h0);
		rchk(pcof_pkg::A_ISTAT, 32'h1);
		$display("test order done");
		// a disabled unit keeps its allocation
		apb(1'b1, pcof_pkg::A_CTRL, 32'h0000_1d01);
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h1, 32'h0001_0040);
		fence();
		chk(gq.size(), 0);
		// media unit takes its entry state from the media pointer command
		pcof_stream_model_i.send(pcof_pkg::OP_FLUSH, 3'h0, 32'h0);
		pcof_stream_model_i.send(pcof_pkg::OP_SELECT, 3'h0, 32'h1);
		pcof_stream_model_i.send(pcof_pkg::OP_MPTR, 3'h4, 32'h0000_0402);
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h4, 32'h0001_0060);
		fence();
		chk(gq.size(), 1);
		gchk(0, 3'h4, 16'h0060, 8'h02, 8'h04);
		$display("test media done");
		// a fence too small for its unit is flagged but still allocates
		pcof_stream_model_i.send(pcof_pkg::OP_FVAL, 3'h4, 32'h0001_0019);
		fence();
		chk(gq.size(), 1);
		rchk(pcof_pkg::A_ISTAT, 32'h9);
		// media object after an unfenced media entry change
		pcof_stream_model_i.send(pcof_pkg::OP_MPTR, 3'h4, 32'h0000_0403);
		pcof_stream_model_i.send(pcof_pkg::OP_MOBJ, 3'h0, 32'h0);
		rchk(pcof_pkg::A_ISTAT, 32'hb);
		$display("test errors done");
		// nothing is taken while the clock enable is low
		ce <= 1'b0;
		pcof_stream_model_i.send(pcof_pkg::OP_SYNC, 3'h0, 32'h0);
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(sync_n, 2);
		$display("test enable done");
		summarize();
	end
endmodule
